// *** inc/pwm_pkg.sv ***
`default_nettype none

package pwm_pkg;

    // ----------------------------------------
    // Register map (byte offsets)
    // ----------------------------------------
    localparam logic [11:0] OFF_STAT = 12'h000;
    localparam logic [11:0] OFF_CTRL = 12'h004;
    localparam logic [11:0] OFF_COUNT = 12'h008;
    localparam logic [11:0] OFF_PRESC = 12'h00C;
    localparam logic [11:0] OFF_PCNT = 12'h010;
    localparam logic [11:0] OFF_MCTL = 12'h014;
    localparam logic [11:0] OFF_MATCH0 = 12'h018;
    localparam logic [11:0] OFF_MATCH6 = 12'h030;
    localparam logic [11:0] OFF_OCTL = 12'h04C;
    localparam logic [11:0] OFF_LATCH = 12'h050;
    localparam logic [11:0] OFF_IMASK = 12'h054;
    localparam logic [11:0] OFF_CCTL = 12'h070;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int CTRL_RUN = 0;
    localparam int CTRL_CLR = 1;
    localparam int CTRL_MOD = 3;
    localparam int CTRL_FOLLOW = 4;
    localparam int CTRL_W = 5;
    localparam int MCTL_INT = 0;
    localparam int MCTL_RST = 1;
    localparam int MCTL_STOP = 2;
    localparam int MCTL_W = 21;
    localparam int OCTL_DBL = 0;
    localparam int OCTL_ENA = 9;
    localparam int OCTL_W = 15;
    localparam int CCTL_W = 4;

    // ----------------------------------------
    // Count source modes
    // ----------------------------------------
    localparam logic [1:0] SRC_TIMER = 2'h0;
    localparam logic [1:0] SRC_RISE = 2'h1;
    localparam logic [1:0] SRC_FALL = 2'h2;
    localparam logic [1:0] SRC_BOTH = 2'h3;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

endpackage : pwm_pkg

`default_nettype wire

// *** hdl/pwm_count_edge.sv ***
`timescale 1ns/100ps
`default_nettype none

module pwm_count_edge (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic sig,
    input wire logic [1:0] mode,
    output logic pulse
);

    logic prev_r;
    wire rise = sig & ~prev_r;
    wire fall = ~sig & prev_r;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= sig;
        end
    end

    assign pulse = (mode == pwm_pkg::SRC_TIMER) ? 1'b1 :
                   (mode == pwm_pkg::SRC_RISE) ? rise :
                   (mode == pwm_pkg::SRC_FALL) ? fall : (rise | fall);

endmodule : pwm_count_edge

`default_nettype wire

// *** hdl/pwm_prescaler.sv ***
`timescale 1ns/100ps
`default_nettype none

module pwm_prescaler #(
    parameter int W = 32
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clr,
    input wire logic step,
    input wire logic [W-1:0] limit,
    output logic [W-1:0] count,
    output logic tick
);

    wire at_limit = (count == limit);

    assign tick = step & at_limit;

    always_ff @(posedge ref_clk) begin
        if (!rst_n || clr) begin
            count <= '0;
        end else if (step) begin
            count <= at_limit ? '0 : count + 1'b1;
        end
    end

endmodule : pwm_prescaler

`default_nettype wire

// *** hdl/pwm_unit.sv ***
// Overview of operation
// RULE_01: Seven compare registers drive up to six single-edge or three double-edge outputs, or a mix.
// RULE_02: Compare register zero sets the period and restarts the counter when matched.
// RULE_03: Single-edge outputs rise at each period match unless their compare value makes them constant low.
// RULE_04: Each single-edge output uses one further compare register to place its falling edge.
// RULE_05: Each double-edge output uses two compare registers, one per edge.
// RULE_06: A rise before the fall gives a positive pulse, a fall first gives a negative pulse.
// RULE_07: Either edge of a double-edge output may sit at any count of the cycle.
// RULE_08: All outputs share the repetition rate of the period register.
// RULE_09: Period and width are any whole number of counts.
// RULE_10: New compare values apply only after software releases them, in step with the outputs.
// RULE_11: With modulation off the unit is a plain timer keeping all compare features.
// RULE_12: The counter is 32 bits and advances through a 32-bit prescaler.
// RULE_13: The counter counts the clock or edges of a selected capture input.
// RULE_14: Each compare may continue, stop or reset the counter, each with optional interrupt.
// RULE_15: Two units run locked when software sets both alike and starts them together, lead then follower.
// RULE_16: Released values move into the active compare set at the period match that opens the next cycle.
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

module pwm_unit #(
    parameter int NM = 7,
    parameter int CW = 32
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] cap_in,
    input wire logic sync_run_in,
    output logic run_out,
    output logic [NM-1:1] pwm_out,
    output logic irq
);

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    logic [NM-1:0] stat_r;
    logic [NM-1:0] imask_r;
    logic [pwm_pkg::CTRL_W-1:0] ctrl_r;
    logic [CW-1:0] tc_r;
    logic [CW-1:0] presc_r;
    logic [pwm_pkg::MCTL_W-1:0] mctl_r;
    logic [pwm_pkg::OCTL_W-1:0] octl_r;
    logic [NM-1:0] latch_r;
    logic [pwm_pkg::CCTL_W-1:0] cctl_r;
    logic [CW-1:0] sh_r [NM];
    logic [CW-1:0] act_r [NM];
    logic [NM-1:1] out_r;
    logic [31:0] rdata_r;

    function automatic logic mbit(input logic [pwm_pkg::MCTL_W-1:0] m, input int i, input int f);
        mbit = m[3 * i + f];
    endfunction : mbit

    function automatic logic is_match(input logic [11:0] a, input int i);
        is_match = (a == 12'(pwm_pkg::OFF_MATCH0 + 4 * i));
    endfunction : is_match

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    wire wr = psel & penable & pwrite;
    wire setup = psel & ~penable;
    wire wr_stat = wr & (paddr == pwm_pkg::OFF_STAT);
    wire wr_ctrl = wr & (paddr == pwm_pkg::OFF_CTRL);
    wire wr_count = wr & (paddr == pwm_pkg::OFF_COUNT);
    wire wr_presc = wr & (paddr == pwm_pkg::OFF_PRESC);
    wire wr_mctl = wr & (paddr == pwm_pkg::OFF_MCTL);
    wire wr_octl = wr & (paddr == pwm_pkg::OFF_OCTL);
    wire wr_latch = wr & (paddr == pwm_pkg::OFF_LATCH);
    wire wr_imask = wr & (paddr == pwm_pkg::OFF_IMASK);
    wire wr_cctl = wr & (paddr == pwm_pkg::OFF_CCTL);
    wire in_match = (paddr >= pwm_pkg::OFF_MATCH0) && (paddr <= pwm_pkg::OFF_MATCH6) && (paddr[1:0] == 2'h0);
    wire mapped = (paddr == pwm_pkg::OFF_STAT) || (paddr == pwm_pkg::OFF_CTRL) ||
                  (paddr == pwm_pkg::OFF_COUNT) || (paddr == pwm_pkg::OFF_PRESC) ||
                  (paddr == pwm_pkg::OFF_PCNT) || (paddr == pwm_pkg::OFF_MCTL) ||
                  (paddr == pwm_pkg::OFF_OCTL) || (paddr == pwm_pkg::OFF_LATCH) ||
                  (paddr == pwm_pkg::OFF_IMASK) || (paddr == pwm_pkg::OFF_CCTL) || in_match;

    // Zero-wait slave: read data is captured in setup, writes and error flagged in access
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata = rdata_r;

    // ----------------------------------------
    // Count source and prescaler
    // ----------------------------------------
    wire pwm_mode = ctrl_r[pwm_pkg::CTRL_MOD];
    wire run = ctrl_r[pwm_pkg::CTRL_RUN] & (~ctrl_r[pwm_pkg::CTRL_FOLLOW] | sync_run_in); // RULE_15
    wire clr = ctrl_r[pwm_pkg::CTRL_CLR];
    wire src_pulse;
    wire tick;
    wire [CW-1:0] pcnt;

    pwm_count_edge u_edge (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .sig(cap_in[cctl_r[3:2]]), // RULE_13
        .mode(cctl_r[1:0]),
        .pulse(src_pulse)
    );

    pwm_prescaler #(.W(CW)) u_presc (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clr(clr | wr_count),
        .step(run & src_pulse), // RULE_12
        .limit(presc_r),
        .count(pcnt),
        .tick(tick)
    );

    // ----------------------------------------
    // Compare and match actions
    // ----------------------------------------
    logic [NM-1:0] hit;
    logic [NM-1:0] rst_sel;
    logic [NM-1:0] stop_sel;
    logic [NM-1:0] int_sel;

    always_comb begin
        for (int i = 0; i < NM; i++) begin
            hit[i] = run & tick & ~clr & (tc_r == act_r[i]); // RULE_09
            int_sel[i] = mbit(mctl_r, i, pwm_pkg::MCTL_INT);
            stop_sel[i] = mbit(mctl_r, i, pwm_pkg::MCTL_STOP);
            rst_sel[i] = mbit(mctl_r, i, pwm_pkg::MCTL_RST);
        end
        rst_sel[0] = rst_sel[0] | pwm_mode; // RULE_02
    end

    wire any_reset = |(hit & rst_sel); // RULE_14
    wire any_stop = |(hit & stop_sel); // RULE_14
    wire [NM-1:0] copy_now = (pwm_mode & hit[0]) ? latch_r : '0; // RULE_16

    // ----------------------------------------
    // Counter
    // ----------------------------------------
    logic [CW-1:0] tc_nxt;
    assign tc_nxt = (clr || any_reset) ? '0 : tick ? tc_r + 1'b1 : tc_r;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            tc_r <= pwm_pkg::RST_WORD;
        end else if (wr_count) begin
            tc_r <= pwdata;
        end else if (run) begin
            tc_r <= tc_nxt; // RULE_02
        end
    end

    // Software write wins over a stop match in the same cycle
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl_r <= '0;
        end else if (wr_ctrl) begin
            ctrl_r <= pwdata[pwm_pkg::CTRL_W-1:0];
        end else if (any_stop) begin
            ctrl_r[pwm_pkg::CTRL_RUN] <= 1'b0; // RULE_14
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            presc_r <= pwm_pkg::RST_WORD;
            mctl_r <= '0;
            octl_r <= '0;
            cctl_r <= '0;
            imask_r <= '0;
        end else begin
            if (wr_presc) presc_r <= pwdata;
            if (wr_mctl) mctl_r <= pwdata[pwm_pkg::MCTL_W-1:0];
            if (wr_octl) octl_r <= pwdata[pwm_pkg::OCTL_W-1:0];
            if (wr_cctl) cctl_r <= pwdata[pwm_pkg::CCTL_W-1:0];
            if (wr_imask) imask_r <= pwdata[NM-1:0];
        end
    end

    // ----------------------------------------
    // Holding and active compare registers
    // ----------------------------------------
    // A release written in the same cycle as a copy survives the copy
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            latch_r <= '0;
        end else if (wr_latch) begin
            latch_r <= pwdata[NM-1:0]; // RULE_10
        end else begin
            latch_r <= latch_r & ~copy_now;
        end
    end

    always_ff @(posedge ref_clk) begin
        for (int i = 0; i < NM; i++) begin
            if (!rst_n) begin
                sh_r[i] <= pwm_pkg::RST_WORD;
                act_r[i] <= pwm_pkg::RST_WORD;
            end else begin
                if (wr && is_match(paddr, i)) sh_r[i] <= pwdata;
                if (!pwm_mode && wr && is_match(paddr, i)) begin
                    act_r[i] <= pwdata; // RULE_11
                end else if (copy_now[i]) begin
                    act_r[i] <= sh_r[i]; // RULE_16
                end
            end
        end
    end

    // ----------------------------------------
    // Modulated outputs
    // ----------------------------------------
    logic [NM-1:1] rise;
    logic [NM-1:1] fall;
    logic [NM-1:1] out_nxt;

    always_comb begin
        for (int k = 1; k < NM; k++) begin
            if (k >= 2 && octl_r[pwm_pkg::OCTL_DBL + k]) begin
                rise[k] = hit[k-1]; // RULE_05
            end else begin
                rise[k] = hit[0] & (act_r[k] != '0); // RULE_03
            end
            fall[k] = hit[k]; // RULE_04
            // Rise before fall gives positive pulse, else negative
            out_nxt[k] = fall[k] ? 1'b0 : rise[k] ? 1'b1 : out_r[k]; // RULE_06
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            out_r <= '0;
        end else if (pwm_mode) begin
            out_r <= out_nxt; // RULE_07
        end else begin
            out_r <= '0;
        end
    end

    // Every output draws its rate from the single period match
    assign pwm_out = out_r & octl_r[pwm_pkg::OCTL_ENA +: NM-1]; // RULE_08 RULE_01
    assign run_out = run;

    // ----------------------------------------
    // Interrupt status
    // ----------------------------------------
    // Hardware set wins over a write-one clear
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            stat_r <= '0;
        end else begin
            stat_r <= (stat_r & ~(wr_stat ? pwdata[NM-1:0] : '0)) | (hit & int_sel); // RULE_14
        end
    end

    assign irq = |(stat_r & imask_r);

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    logic [31:0] rsel;

    always_comb begin
        rsel = 32'h0000_0000;
        case (paddr)
            pwm_pkg::OFF_STAT: rsel = 32'(stat_r);
            pwm_pkg::OFF_CTRL: rsel = 32'(ctrl_r);
            pwm_pkg::OFF_COUNT: rsel = tc_r;
            pwm_pkg::OFF_PRESC: rsel = presc_r;
            pwm_pkg::OFF_PCNT: rsel = pcnt;
            pwm_pkg::OFF_MCTL: rsel = 32'(mctl_r);
            pwm_pkg::OFF_OCTL: rsel = 32'(octl_r);
            pwm_pkg::OFF_LATCH: rsel = 32'(latch_r);
            pwm_pkg::OFF_IMASK: rsel = 32'(imask_r);
            pwm_pkg::OFF_CCTL: rsel = 32'(cctl_r);
            default: begin
                for (int i = 0; i < NM; i++) begin
                    if (is_match(paddr, i)) rsel = sh_r[i];
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rdata_r <= 32'h0000_0000;
        end else if (setup) begin
            rdata_r <= rsel;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_period_restart: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_02
        (pwm_mode && hit[0] && !wr_count) |=> (tc_r == '0))
        else $error("period match did not restart counter");

    a_single_rise: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_03
        (pwm_mode && hit[0] && !hit[1] && act_r[1] != '0) |=> out_r[1])
        else $error("single edge output did not rise at period match");

    a_single_fall: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_04
        (pwm_mode && hit[1]) |=> !out_r[1])
        else $error("output did not fall at its match");

    a_double_rise: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_05
        (pwm_mode && octl_r[pwm_pkg::OCTL_DBL + 2] && hit[1] && !hit[2]) |=> out_r[2])
        else $error("double edge output did not rise at its match");

    a_release_copy: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_16
        (pwm_mode && hit[0] && latch_r[1]) |=> (act_r[1] == $past(sh_r[1]) && !latch_r[1] || $past(wr_latch)))
        else $error("released value not applied at period match");

    a_hold_active: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_10
        (pwm_mode && !hit[0]) |=> (act_r[1] == $past(act_r[1])))
        else $error("active compare changed outside period match");

    a_stop_match: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_14
        (hit[1] && stop_sel[1] && !wr_ctrl) |=> !ctrl_r[pwm_pkg::CTRL_RUN] ##1 (tc_r == $past(tc_r)))
        else $error("stop on match did not halt counter");

    a_stat_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_14
        (stat_r[1] && !wr_stat) |=> stat_r[1])
        else $error("status bit lost without clear");

    a_presc_gate: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_12
        (run && !tick && !clr && !wr_count) |=> (tc_r == $past(tc_r)))
        else $error("counter moved without prescaler tick");

endmodule : pwm_unit

`default_nettype wire

// *** sim/pwm_load.sv ***
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// Load on the modulated outputs
// ----------------------------------------
// Reports {high cycles, period cycles} of the selected output at each rising edge.
// The first report after a change of sel is junk, so callers let it settle.
module pwm_load (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [6:1] drive,
    input wire logic [2:0] sel,
    output logic meas_valid,
    output logic [31:0] meas
);
    logic prev_r;
    logic [15:0] hcnt_r;
    logic [15:0] pcnt_r;
    wire logic cur = drive[sel];
    wire logic rise = cur && !prev_r;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            prev_r <= 1'b0;
            hcnt_r <= 16'h0;
            pcnt_r <= 16'h0;
            meas_valid <= 1'b0;
            meas <= 32'h0;
        end else begin
            prev_r <= cur;
            meas_valid <= rise;
            if (rise) begin
                meas <= {hcnt_r, pcnt_r};
                hcnt_r <= 16'h1;
                pcnt_r <= 16'h1;
            end else begin
                pcnt_r <= pcnt_r + 16'h1;
                hcnt_r <= hcnt_r + {15'h0, cur};
            end
        end
    end
endmodule : pwm_load

`default_nettype wire

// *** sim/dual_edge_pulse_width_modulator_tb.sv ***
`timescale 1ns/100ps
`default_nettype none

module dual_edge_pulse_width_modulator_tb;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic sync_run_in = 1'b0;
    logic arm = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] cap_in = 4'h0;
    logic [2:0] sel = 3'h1;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic run_out;
    logic irq;
    logic [6:1] pwm_out;
    logic meas_valid;
    logic [31:0] meas;
    logic [31:0] rs = 32'h586CE20E;
    logic [32:0] reg_q[$];
    logic [31:0] pwm_q[$];
    int errors = 0;
    int check_count = 0;

    always #2.5 ref_clk = ~ref_clk;

    pwm_unit i_pwm_unit (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cap_in(cap_in),
        .sync_run_in(sync_run_in), .run_out(run_out), .pwm_out(pwm_out), .irq(irq));
    pwm_load i_pwm_load (.ref_clk(ref_clk), .rst_n(rst_n), .drive(pwm_out), .sel(sel),
        .meas_valid(meas_valid), .meas(meas));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction : rnd

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : check

    task automatic end_sim();
        $display("errors=%0d checks=%0d", errors, check_count);
        if (errors == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim

    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (n >= 100) errors++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        reg_q.push_back(e);
        xfer(a, 1'b0, 32'h0);
    endtask : rd

    // Settle over several cycles, then compare the next rising-edge report
    task automatic meas_out(input logic [2:0] k, input int hi, input int per);
        int n;
        sel <= k;
        repeat (3 * per + 10) @(posedge ref_clk);
        pwm_q.push_back({hi[15:0], per[15:0]});
        arm <= 1'b1;
        n = 0;
        while (pwm_q.size() > 0 && n < 1000) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 1000) errors++;
        arm <= 1'b0;
    endtask : meas_out

    function automatic int dbl(input int r, input int f, input int p);
        return (f > r) ? f - r : p + 1 - (r - f);
    endfunction : dbl

    always @(posedge ref_clk) begin
        if (psel && penable && pready && !pwrite && reg_q.size() > 0) begin
            check({pslverr, prdata}, reg_q.pop_front());
        end
        if (arm && meas_valid && pwm_q.size() > 0) check(meas, pwm_q.pop_front());
    end

    initial begin
        repeat (50000) @(posedge ref_clk);
        errors++;
        end_sim();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [11:0] offs[10];
        logic [31:0] r;
        int m[7];
        int p;
        int n;
        logic hi;
        offs = '{pwm_pkg::OFF_STAT, pwm_pkg::OFF_CTRL, pwm_pkg::OFF_COUNT, pwm_pkg::OFF_PRESC,
            pwm_pkg::OFF_MCTL, pwm_pkg::OFF_MATCH0, pwm_pkg::OFF_OCTL, pwm_pkg::OFF_LATCH,
            pwm_pkg::OFF_IMASK, pwm_pkg::OFF_CCTL};
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 10; i++) rd(offs[i], 33'h0);
        rd(12'h100, {1'b1, 32'h0});
        // Edge counting on input 0, others carry noise
        xfer(pwm_pkg::OFF_CCTL, 1'b1, 32'h1);
        xfer(pwm_pkg::OFF_CTRL, 1'b1, 32'h1);
        for (int i = 0; i < 5; i++) begin
            r = rnd();
            @(posedge ref_clk);
            cap_in <= {r[3:1], 1'b1};
            @(posedge ref_clk);
            cap_in <= {r[6:4], 1'b0};
        end
        repeat (4) @(posedge ref_clk);
        xfer(pwm_pkg::OFF_CTRL, 1'b1, 32'h0);
        rd(pwm_pkg::OFF_COUNT, 33'h5);
        // Falling edges on input 2, others carry noise
        xfer(pwm_pkg::OFF_CCTL, 1'b1, 32'hA);
        xfer(pwm_pkg::OFF_COUNT, 1'b1, 32'h0);
        xfer(pwm_pkg::OFF_CTRL, 1'b1, 32'h1);
        for (int i = 0; i < 3; i++) begin
            r = rnd();
            @(posedge ref_clk);
            cap_in <= {r[3], 1'b1, r[1:0]};
            @(posedge ref_clk);
            cap_in <= {r[6], 1'b0, r[5:4]};
        end
        repeat (4) @(posedge ref_clk);
        xfer(pwm_pkg::OFF_CTRL, 1'b1, 32'h0);
        rd(pwm_pkg::OFF_COUNT, 33'h3);
        // Follower held by sync input, then match 1 interrupts and stops
        xfer(pwm_pkg::OFF_CCTL, 1'b1, 32'h0);
        xfer(pwm_pkg::OFF_COUNT, 1'b1, 32'h0);
        xfer(pwm_pkg::OFF_CTRL, 1'b1, 32'h11);
        repeat (10) @(posedge ref_clk);
        rd(pwm_pkg::OFF_COUNT, 33'h0);
        @(negedge ref_clk);
        check(run_out, 1'b0);
        xfer(pwm_pkg::OFF_MATCH0 + 12'h004, 1'b1, 32'h14);
        xfer(pwm_pkg::OFF_MCTL, 1'b1, 32'h28);
        xfer(pwm_pkg::OFF_IMASK, 1'b1, 32'h2);
        sync_run_in <= 1'b1;
        @(negedge ref_clk);
        check(run_out, 1'b1);
        n = 0;
        while (irq !== 1'b1 && n < 200) begin
            @(negedge ref_clk);
            n++;
        end
        check(irq, 1'b1);
        check(run_out, 1'b0);
        rd(pwm_pkg::OFF_CTRL, 33'h10);
        rd(pwm_pkg::OFF_STAT, 33'h2);
        xfer(pwm_pkg::OFF_IMASK, 1'b1, 32'h0);
        @(negedge ref_clk);
        check(irq, 1'b0);
        xfer(pwm_pkg::OFF_STAT, 1'b1, 32'h2);
        xfer(pwm_pkg::OFF_IMASK, 1'b1, 32'h2);
        @(negedge ref_clk);
        check(irq, 1'b0);
        rd(pwm_pkg::OFF_STAT, 33'h0);
        sync_run_in <= 1'b0;
        xfer(pwm_pkg::OFF_CTRL, 1'b1, 32'h0);
        xfer(pwm_pkg::OFF_MCTL, 1'b1, 32'h0);
        // Six single-edge outputs, output 3 constant low
        p = 20 + int'(rnd() % 20);
        m[1] = 1 + int'(rnd() % (p / 2));
        m[2] = p - 1 - int'(rnd() % (p / 2 - 1));
        for (int k = 4; k < 7; k++) m[k] = 1 + int'(rnd() % (p - 1));
        m[3] = 0;
        xfer(pwm_pkg::OFF_COUNT, 1'b1, 32'h0);
        xfer(pwm_pkg::OFF_MATCH0, 1'b1, p);
        for (int k = 1; k < 7; k++) xfer(pwm_pkg::OFF_MATCH0 + 12'(4 * k), 1'b1, m[k]);
        rd(pwm_pkg::OFF_MATCH0 + 12'h004, {1'b0, m[1]});
        xfer(pwm_pkg::OFF_OCTL, 1'b1, 32'h7E00);
        xfer(pwm_pkg::OFF_LATCH, 1'b1, 32'h7F);
        xfer(pwm_pkg::OFF_CTRL, 1'b1, 32'h9);
        for (int k = 1; k < 7; k++) if (k != 3) meas_out(k, m[k] + 1, p + 1);
        hi = 1'b0;
        repeat (2 * p) begin
            @(negedge ref_clk);
            hi |= pwm_out[3];
        end
        check(hi, 1'b0);
        // Output 2 double-edge; unreleased swap must not apply
        xfer(pwm_pkg::OFF_OCTL, 1'b1, 32'h7E04);
        meas_out(2, dbl(m[1], m[2], p), p + 1);
        xfer(pwm_pkg::OFF_MATCH0 + 12'h004, 1'b1, m[2]);
        xfer(pwm_pkg::OFF_MATCH0 + 12'h008, 1'b1, m[1]);
        meas_out(2, dbl(m[1], m[2], p), p + 1);
        xfer(pwm_pkg::OFF_LATCH, 1'b1, 32'h6);
        meas_out(2, dbl(m[2], m[1], p), p + 1);
        xfer(pwm_pkg::OFF_PRESC, 1'b1, 32'h1);
        meas_out(1, 2 * (m[2] + 1), 2 * (p + 1));
        end_sim();
    end
endmodule : dual_edge_pulse_width_modulator_tb

`default_nettype wire
